// [verilog/fpc_defs.svh]
// Field layouts, biases and sizes of the four floating-point formats
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// Sign bit positions, sign at the top of each format
`define FPC_H_SIGN 15
`define FPC_S_SIGN 31
`define FPC_D_SIGN 63
`define FPC_E_SIGN 79
// Exponent field widths
`define FPC_H_EW 5
`define FPC_S_EW 8
`define FPC_D_EW 11
`define FPC_E_EW 15
// Fraction field widths
`define FPC_H_FW 10
`define FPC_S_FW 23
`define FPC_D_FW 52
`define FPC_E_FW 63
// Explicit integer bit of the extended format
`define FPC_E_INT 63
// Exponent biases
`define FPC_H_BIAS 15'h000f
`define FPC_S_BIAS 15'h007f
`define FPC_D_BIAS 15'h03ff
`define FPC_E_BIAS 15'h3fff
// Memory image size in bytes
`define FPC_H_BYTES 4'h2
`define FPC_S_BYTES 4'h4
`define FPC_D_BYTES 4'h8
`define FPC_E_BYTES 4'ha
// One-hot class flag positions
`define FPC_C_ZERO 0
`define FPC_C_DENORM 1
`define FPC_C_NORMAL 2
`define FPC_C_INF 3
`define FPC_C_SIGNALLING_NAN 4
`define FPC_C_QUIET_NAN 5
`define FPC_NCLS 6
`endif

// [verilog/fpc_pkg.sv]
// Types shared by the floating-point classifier
package fpc_pkg;
  // Operand format select
  typedef enum logic [1:0] {FMT_HALF, FMT_SINGLE, FMT_DOUBLE, FMT_EXT} fmt_t;
  // Unit that issues the operand
  typedef enum logic {UNIT_STACK, UNIT_VECTOR} unit_t;
endpackage

// [verilog/float_format_classifier.sv]
// Two-stage unpacker and classifier for half, single, double and extended operands
`timescale 1ns/10ps
`include "fpc_defs.svh"

// How it works
// - Standard binary interchange layouts for half, single, double; extended keeps an explicit integer bit
// - Half accepted only for conversion requests
// - Fixed precision, exponent and fraction widths
// - Exponent zero with nonzero fraction is denormal
// - Single and double store fraction only
// - Implied integer one, zero for zero/denormal
// - Extended integer bit 63, fraction top 62
// - Extended integer bit one except zero/denormal
// - Exponent decides zero, denormal, normal, infinity
// - Fraction top bit splits signalling/quiet NaN
// - Indefinite: sign one, quiet, only top bit
// - Biases 15, 127, 1023, 16383
// - Images take 2, 4, 8, 10 bytes
// - Extended only from stack unit
// - Sign zero positive, one negative
module float_format_classifier (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Operand request
  input wire logic in_valid,
  input wire fpc_pkg::fmt_t in_format,
  input wire fpc_pkg::unit_t in_unit,
  input wire logic in_conv,
  input wire logic [79:0] in_operand,
  // Unpacked result
  output logic out_valid,
  output logic out_reject,
  output logic [`FPC_NCLS-1:0] out_class,
  output logic out_indefinite,
  output logic out_int_bad,
  output logic out_sign,
  output logic [14:0] out_exp,
  output logic signed [16:0] out_exp_unb,
  output logic [63:0] out_signif,
  output logic [3:0] out_bytes
);

  // Input stage registers
  logic vld_ff;
  fpc_pkg::fmt_t fmt_ff;
  fpc_pkg::unit_t unit_ff;
  logic conv_ff;
  logic [79:0] op_ff;

  // Operand stage: every request is registered first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vld_ff <= 1'b0;
      fmt_ff <= fpc_pkg::FMT_HALF;
      unit_ff <= fpc_pkg::UNIT_STACK;
      conv_ff <= 1'b0;
      op_ff <= 80'h0;
    end else begin
      vld_ff <= in_valid;
      fmt_ff <= in_format;
      unit_ff <= in_unit;
      conv_ff <= in_conv;
      op_ff <= in_operand;
    end
  end

  // Per-format fields, fraction left-aligned to 63 bits
  // sign top, exponent, fraction
  wire h_sign = op_ff[`FPC_H_SIGN];
  wire s_sign = op_ff[`FPC_S_SIGN];
  wire d_sign = op_ff[`FPC_D_SIGN];
  wire e_sign = op_ff[`FPC_E_SIGN];
  wire [14:0] h_exp = {{(15-`FPC_H_EW){1'b0}}, op_ff[`FPC_H_SIGN-1 -: `FPC_H_EW]};
  wire [14:0] s_exp = {{(15-`FPC_S_EW){1'b0}}, op_ff[`FPC_S_SIGN-1 -: `FPC_S_EW]};
  wire [14:0] d_exp = {{(15-`FPC_D_EW){1'b0}}, op_ff[`FPC_D_SIGN-1 -: `FPC_D_EW]};
  wire [14:0] e_exp = op_ff[`FPC_E_SIGN-1 -: `FPC_E_EW];
  // single and double carry fraction only
  wire [62:0] h_frac = {op_ff[`FPC_H_FW-1:0], {(63-`FPC_H_FW){1'b0}}};
  wire [62:0] s_frac = {op_ff[`FPC_S_FW-1:0], {(63-`FPC_S_FW){1'b0}}};
  wire [62:0] d_frac = {op_ff[`FPC_D_FW-1:0], {(63-`FPC_D_FW){1'b0}}};
  // extended integer at 63, fraction from 62 down
  wire [62:0] e_frac = op_ff[`FPC_E_FW-1:0];
  wire e_int = op_ff[`FPC_E_INT];

  // Format selection
  wire is_half = (fmt_ff == fpc_pkg::FMT_HALF);
  wire is_single = (fmt_ff == fpc_pkg::FMT_SINGLE);
  wire is_double = (fmt_ff == fpc_pkg::FMT_DOUBLE);
  wire is_ext = (fmt_ff == fpc_pkg::FMT_EXT);
  // sign bit passed as is, one means negative
  wire sel_sign = is_half ? h_sign : is_single ? s_sign : is_double ? d_sign : e_sign;
  wire [14:0] sel_exp = is_half ? h_exp : is_single ? s_exp : is_double ? d_exp : e_exp;
  wire [62:0] sel_frac = is_half ? h_frac : is_single ? s_frac : is_double ? d_frac : e_frac;
  // All-ones exponent for the selected width
  wire [14:0] exp_max = is_half ? 15'h001f : is_single ? 15'h00ff :
                        is_double ? 15'h07ff : 15'h7fff;
  wire [14:0] sel_bias = is_half ? `FPC_H_BIAS : is_single ? `FPC_S_BIAS :
                         is_double ? `FPC_D_BIAS : `FPC_E_BIAS;
  wire [3:0] sel_bytes = is_half ? `FPC_H_BYTES : is_single ? `FPC_S_BYTES :
                         is_double ? `FPC_D_BYTES : `FPC_E_BYTES;

  // Exponent and fraction conditions
  wire exp_zero = (sel_exp == 15'h0);
  wire exp_ones = (sel_exp == exp_max);
  wire frac_zero = (sel_frac == 63'h0);
  wire frac_top = sel_frac[62];

  wire c_zero = exp_zero && frac_zero;
  wire c_denorm = exp_zero && !frac_zero;
  wire c_normal = !exp_zero && !exp_ones;
  wire c_inf = exp_ones && frac_zero;
  // fraction top bit picks the NaN kind
  wire c_signalling_nan = exp_ones && !frac_zero && !frac_top;
  wire c_quiet_nan = exp_ones && frac_top;
  wire [`FPC_NCLS-1:0] sel_class = {c_quiet_nan, c_signalling_nan, c_inf, c_normal, c_denorm, c_zero};

  // implied integer bit, zero for zero and denormal
  wire implied_int = !exp_zero;
  // extended integer bit is explicit, mismatch flagged
  wire sel_int = is_ext ? e_int : implied_int;
  wire int_bad = is_ext && (e_int != implied_int);

  // indefinite is negative quiet NaN with lone top fraction bit
  wire indef = sel_sign && exp_ones && (sel_frac == 63'h4000_0000_0000_0000) && sel_int;

  // Unbiased exponent; denormals use the minimum exponent
  wire [14:0] exp_eff = exp_zero ? 15'h0001 : sel_exp;
  wire signed [16:0] exp_unb = $signed({2'b00, exp_eff}) - $signed({2'b00, sel_bias});

  // half only on a conversion request
  wire rej_half = is_half && !conv_ff;
  // extended refused from the vector unit
  wire rej_ext = is_ext && (unit_ff == fpc_pkg::UNIT_VECTOR);
  // refused operands still decode to standard fields
  wire reject = rej_half || rej_ext;

  // Result stage: all outputs come from these flip-flops
  // results one cycle after the operand stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_reject <= 1'b0;
      out_class <= '0;
      out_indefinite <= 1'b0;
      out_int_bad <= 1'b0;
      out_sign <= 1'b0;
      out_exp <= 15'h0;
      out_exp_unb <= 17'sh0;
      out_signif <= 64'h0;
      out_bytes <= 4'h0;
    end else begin
      out_valid <= vld_ff;
      out_reject <= vld_ff && reject;
      out_class <= vld_ff ? sel_class : '0;
      out_indefinite <= vld_ff && indef;
      out_int_bad <= vld_ff && int_bad;
      out_sign <= sel_sign;
      out_exp <= sel_exp;
      out_exp_unb <= exp_unb;
      out_signif <= {sel_int, sel_frac};
      out_bytes <= sel_bytes;
    end
  end

  // Request taken and answer two edges later
  sequence s_take;
    in_valid;
  endsequence
  sequence s_answer;
    ##2 out_valid;
  endsequence

  property p_latency;
    @(posedge sys_clk) disable iff (!reset_n) s_take |-> s_answer;
  endproperty
  a_latency: assert property (p_latency) else $error("result not two cycles after request");

  property p_onehot;
    @(posedge sys_clk) disable iff (!reset_n) out_valid |-> $onehot(out_class);
  endproperty
  a_onehot: assert property (p_onehot) else $error("class flags not one-hot");

  property p_bytes;
    @(posedge sys_clk) disable iff (!reset_n)
      in_valid && in_format == fpc_pkg::FMT_EXT |-> ##2 out_bytes == 4'ha;
  endproperty
  a_bytes: assert property (p_bytes) else $error("extended image size wrong");

  property p_sign;
    @(posedge sys_clk) disable iff (!reset_n)
      in_valid && in_format == fpc_pkg::FMT_SINGLE |-> ##2 out_sign == $past(in_operand[31], 2);
  endproperty
  a_sign: assert property (p_sign) else $error("single sign not from bit 31");

  property p_implied;
    @(posedge sys_clk) disable iff (!reset_n)
      in_valid && in_format == fpc_pkg::FMT_DOUBLE |->
        ##2 out_signif[63] == ($past(in_operand[62:52], 2) != 11'h0);
  endproperty
  a_implied: assert property (p_implied) else $error("double implied bit wrong");

  property p_ext_int;
    @(posedge sys_clk) disable iff (!reset_n)
      in_valid && in_format == fpc_pkg::FMT_EXT |-> ##2 out_signif == $past(in_operand[63:0], 2);
  endproperty
  a_ext_int: assert property (p_ext_int) else $error("extended significand not bits 63:0");

  property p_nan_kind;
    @(posedge sys_clk) disable iff (!reset_n)
      out_class[`FPC_C_SIGNALLING_NAN] || out_class[`FPC_C_QUIET_NAN] |->
        out_class[`FPC_C_QUIET_NAN] == out_signif[62];
  endproperty
  a_nan_kind: assert property (p_nan_kind) else $error("NaN kind disagrees with top bit");

  property p_indef;
    @(posedge sys_clk) disable iff (!reset_n)
      out_indefinite |-> out_sign && out_class[`FPC_C_QUIET_NAN] && out_signif[63];
  endproperty
  a_indef: assert property (p_indef) else $error("indefinite not a negative quiet NaN");

  property p_half_rej;
    @(posedge sys_clk) disable iff (!reset_n)
      in_valid && in_format == fpc_pkg::FMT_HALF && !in_conv |-> ##2 out_reject;
  endproperty
  a_half_rej: assert property (p_half_rej) else $error("half outside conversion not refused");

  // Bias recovered from the reported image size, so the check does not reuse the stage mux
  wire [14:0] res_bias = (out_bytes == `FPC_H_BYTES) ? `FPC_H_BIAS :
                         (out_bytes == `FPC_S_BYTES) ? `FPC_S_BIAS :
                         (out_bytes == `FPC_D_BYTES) ? `FPC_D_BIAS : `FPC_E_BIAS;

  property p_bias;
    @(posedge sys_clk) disable iff (!reset_n)
      out_valid && out_class[`FPC_C_NORMAL] |->
        out_exp_unb == $signed({2'b00, out_exp}) - $signed({2'b00, res_bias});
  endproperty
  a_bias: assert property (p_bias) else $error("unbiased exponent wrong");

endmodule

// [verif/float_format_classifier_tb_top.sv]
// Self-checking bench for the floating-point format classifier
`timescale 1ns/10ps
module float_format_classifier_tb_top;
  // Clock, reset and request drive
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic in_valid = 1'b0;
  fpc_pkg::fmt_t in_format = fpc_pkg::FMT_SINGLE;
  fpc_pkg::unit_t in_unit = fpc_pkg::UNIT_STACK;
  logic in_conv = 1'b0;
  logic [79:0] in_operand = 80'h0;
  // Outputs under test
  logic out_valid, out_reject, out_indefinite, out_int_bad, out_sign;
  logic [5:0] out_class;
  logic [14:0] out_exp;
  logic signed [16:0] out_exp_unb;
  logic [63:0] out_signif;
  logic [3:0] out_bytes;
  // Tallies and cycle count for the hang guard
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  float_format_classifier uut (.sys_clk(sys_clk), .reset_n(reset_n), .in_valid(in_valid),
    .in_format(in_format), .in_unit(in_unit), .in_conv(in_conv), .in_operand(in_operand),
    .out_valid(out_valid), .out_reject(out_reject), .out_class(out_class),
    .out_indefinite(out_indefinite), .out_int_bad(out_int_bad), .out_sign(out_sign),
    .out_exp(out_exp), .out_exp_unb(out_exp_unb), .out_signif(out_signif),
    .out_bytes(out_bytes));

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;

  // Hang guard, far above the roughly 125 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Closing report
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One comparison, four-state exact
  task chk(input logic [79:0] got, input logic [79:0] want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  // Issue one operand, work out its unpacked form and compare the answer
  task automatic op(input fpc_pkg::fmt_t f, input fpc_pkg::unit_t u, input logic c,
                    input logic [79:0] x);
    int fw, ew, n, sh;
    logic [14:0] e;
    logic [62:0] fr;
    logic ib, top, sgn;
    logic [5:0] cl;
    logic signed [16:0] ub;
    fw = (f == fpc_pkg::FMT_HALF) ? 10 : (f == fpc_pkg::FMT_SINGLE) ? 23 :
         (f == fpc_pkg::FMT_DOUBLE) ? 52 : 63;
    ew = (f == fpc_pkg::FMT_HALF) ? 5 : (f == fpc_pkg::FMT_SINGLE) ? 8 :
         (f == fpc_pkg::FMT_DOUBLE) ? 11 : 15;
    // Extended keeps its integer bit between fraction and exponent
    sh = (f == fpc_pkg::FMT_EXT) ? 64 : fw;
    sgn = x[sh + ew];
    e = 15'((x >> sh) & ((80'h1 << ew) - 80'h1));
    fr = 63'((x & ((80'h1 << fw) - 80'h1)) << (63 - fw));
    ib = (f == fpc_pkg::FMT_EXT) ? x[63] : (e != 15'h0);
    top = (e == 15'((80'h1 << ew) - 80'h1));
    cl = (e == 15'h0) ? ((fr == 63'h0) ? 6'h01 : 6'h02) : !top ? 6'h04 :
         (fr == 63'h0) ? 6'h08 : fr[62] ? 6'h20 : 6'h10;
    ub = $signed({2'h0, (e == 15'h0) ? 15'h1 : e}) - $signed(17'((80'h1 << (ew - 1)) - 80'h1));
    @(negedge sys_clk);
    in_valid = 1'b1;
    in_format = f;
    in_unit = u;
    in_conv = c;
    in_operand = x;
    @(negedge sys_clk);
    in_valid = 1'b0;
    n = 1;
    while (out_valid !== 1'b1 && n < 4) begin
      chk(out_class, 80'h0);
      @(negedge sys_clk);
      n++;
    end
    chk(n, 2);
    chk(out_class, cl);
    chk(out_reject, (f == fpc_pkg::FMT_HALF && !c) || (f == fpc_pkg::FMT_EXT && u));
    chk(out_indefinite, sgn && top && ib && fr == {1'b1, 62'h0});
    chk(out_int_bad, f == fpc_pkg::FMT_EXT && x[63] != (e != 15'h0));
    chk(out_sign, sgn);
    chk(out_exp, e);
    chk(80'(out_exp_unb), 80'(ub));
    chk(out_signif, {ib, fr});
    chk(out_bytes, (f == fpc_pkg::FMT_EXT) ? 4'ha : 4'((fw + ew + 1) / 8));
    @(negedge sys_clk);
    chk(out_valid, 1'b0);
  endtask

  // Single: every class, signs and indefinite
  task t_single;
    logic [79:0] v[8];
    v = '{80'h0, 80'h8000_0001, 80'h3f80_0000, 80'h7f80_0000, 80'h7fa0_0000,
          80'h7fc0_0000, 80'hffc0_0000, 80'h7f7f_ffff};
    for (int i = 0; i < 8; i++)
      op(fpc_pkg::FMT_SINGLE, fpc_pkg::UNIT_STACK, 1'b0, v[i]);
    $display("single test done");
  endtask

  // Double from the vector unit
  task t_double;
    logic [79:0] v[6];
    v = '{80'h8000_0000_0000_0000, 80'h000f_ffff_ffff_ffff, 80'hbff0_0000_0000_0000,
          80'h7ff0_0000_0000_0000, 80'h7ff4_0000_0000_0000, 80'hfff8_0000_0000_0000};
    for (int i = 0; i < 6; i++)
      op(fpc_pkg::FMT_DOUBLE, fpc_pkg::UNIT_VECTOR, 1'b0, v[i]);
    $display("double test done");
  endtask

  // Extended with explicit integer bit, unnormal, and a vector-unit refusal
  task t_ext;
    logic [79:0] v[7];
    v = '{80'h0, 80'h0000_7fff_ffff_ffff_ffff, 80'h3fff_8000_0000_0000_0000,
          80'h7fff_8000_0000_0000_0000, 80'h7fff_a000_0000_0000_0000,
          80'hffff_c000_0000_0000_0000, 80'h3fff_0000_0000_0000_0001};
    for (int i = 0; i < 7; i++)
      op(fpc_pkg::FMT_EXT, fpc_pkg::UNIT_STACK, 1'b0, v[i]);
    op(fpc_pkg::FMT_EXT, fpc_pkg::UNIT_VECTOR, 1'b0, v[2]);
    $display("extended test done");
  endtask

  // Half as conversion, then as arithmetic, first operand with junk in the upper bits
  task t_half;
    logic [79:0] v[6];
    v = '{80'ha5a5_0000_0000_0000_0000, 80'h1, 80'h3c00, 80'h7c00, 80'h7d00, 80'hfe00};
    for (int i = 0; i < 6; i++)
      op(fpc_pkg::FMT_HALF, fpc_pkg::UNIT_VECTOR, 1'b1, v[i]);
    op(fpc_pkg::FMT_HALF, fpc_pkg::UNIT_STACK, 1'b0, v[2]);
    $display("half test done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    t_single();
    t_double();
    t_ext();
    t_half();
    give_verdict();
  end
endmodule
